// File: ssa_pkg.sv
// Package for subsystem alias and PLL ratio configuration registers
package ssa_pkg;
  // Configuration offsets (byte addresses, dword aligned)
  localparam logic [7:0]  SSA_OFS_SUBSYS_VEND = 8'h2C;
  localparam logic [7:0]  SSA_OFS_ALIAS       = 8'h50;
  localparam logic [7:0]  SSA_OFS_PLLCFG      = 8'h54;
  // Reset values
  localparam logic [31:0] SSA_ALIAS_RST       = 32'h0000_0000;
  localparam logic [31:0] SSA_PLLCFG_RST      = 32'h0000_0305;
  // Field positions
  localparam int          SSA_DEV_LSB         = 16;
  localparam int          SSA_MAKER_LSB       = 0;
  localparam int          SSA_TEST_BIT        = 16;
  localparam int          SSA_N_LSB           = 8;
  localparam int          SSA_N_W             = 3;
  localparam int          SSA_M_LSB           = 0;
  localparam int          SSA_M_W             = 5;
  // Writable bits of the PLL configuration register
  localparam logic [31:0] SSA_PLLCFG_WMASK    = 32'h0001_071F;
  // PLL output and derived core clocks, in MHz
  localparam int          SSA_PLL_OUT_MHZ     = 80;
  localparam int          SSA_CORE_FAST_MHZ   = 40;
  localparam int          SSA_CORE_SLOW_MHZ   = 20;
  localparam int          SSA_DIV_FAST        = SSA_PLL_OUT_MHZ / SSA_CORE_FAST_MHZ;
  localparam int          SSA_DIV_SLOW        = SSA_PLL_OUT_MHZ / SSA_CORE_SLOW_MHZ;
endpackage

// File: ssa_cfg_regs.sv
// Subsystem alias and PLL ratio/test configuration registers
`timescale 1ns/1ps
// Functional notes
// - A 32-bit read/write alias at 50h resets to zero and mirrors the subsystem id registers.
// - The upper half of the alias is what the subsystem device id register at 2Eh returns.
// - The lower half of the alias is what the subsystem vendor id register at 2Ch returns.
// - The default ratio fields drive the PLL to an 80 MHz output.
// - The PLL output is divided down to 40 MHz and 20 MHz clocks for the media cores.
// - The PLL configuration register returns to default only on the global reset.
// - Test bit 16 shortens the clock-valid wait and the card-detect debounce times.
// - Bits 10 to 8 are the read/write N ratio field, reset value 3.
// - Bits 4 to 0 are the read/write M ratio field, reset value 5.
// - Bits 15 to 11 read zero and ignore writes.
// - Bits 7 to 5 read zero and ignore writes.
// - Bits 31 to 17 are read-only and writes to them change nothing.
module ssa_cfg_regs
(
  // Clock and resets
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        global_reset_pin_n,
  // Configuration access
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_hit,
  // PLL control
  output logic      [2:0]  pll_n_ratio,
  output logic      [4:0]  pll_m_ratio,
  output logic             pll_test_mode,
  // Derived core clock enables from PLL
  input  wire logic        pll_clk,
  output logic             core_fast_tick,
  output logic             core_slow_tick
);
  import ssa_pkg::*;

  typedef struct packed {
    logic [31:0] alias_w;
    logic [31:0] pllcfg;
    logic [31:0] rdata;
    logic        hit;
  } ssa_state_type;

  ssa_state_type st_r;
  ssa_state_type st_nxt;
  logic [1:0]    div_r;
  logic [31:0]   byte_mask;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      byte_mask[i*8 +: 8] = {8{cfg_be[i]}};
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.hit = 1'b0;
    if (cfg_wr && cfg_addr[7:2] == SSA_OFS_ALIAS[7:2])
    begin
      st_nxt.alias_w = (st_r.alias_w & ~byte_mask) | (cfg_wdata & byte_mask);
    end
    if (cfg_wr && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2])
    begin
      // Only test, N and M bits take writes; all others stay zero
      st_nxt.pllcfg = (st_r.pllcfg & ~(byte_mask & SSA_PLLCFG_WMASK))
                    | (cfg_wdata & byte_mask & SSA_PLLCFG_WMASK);
    end
    if (cfg_rd)
    begin
      st_nxt.hit = 1'b1;
      case (cfg_addr[7:2])
        SSA_OFS_SUBSYS_VEND[7:2]: st_nxt.rdata = st_r.alias_w;
        SSA_OFS_ALIAS[7:2]:       st_nxt.rdata = st_r.alias_w;
        SSA_OFS_PLLCFG[7:2]:      st_nxt.rdata = st_r.pllcfg & SSA_PLLCFG_WMASK;
        default:
        begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.hit   = 1'b0;
        end
      endcase
    end
  end

  // Alias and read path follow bus reset; PLL register only global reset
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_r.alias_w <= SSA_ALIAS_RST;
      st_r.rdata   <= 32'h0000_0000;
      st_r.hit     <= 1'b0;
    end
    else
    begin
      st_r.alias_w <= st_nxt.alias_w;
      st_r.rdata   <= st_nxt.rdata;
      st_r.hit     <= st_nxt.hit;
    end
    if (!global_reset_pin_n)
    begin
      st_r.pllcfg <= SSA_PLLCFG_RST;
    end
    else
    begin
      st_r.pllcfg <= st_nxt.pllcfg;
    end
  end

  assign cfg_rdata     = st_r.rdata;
  assign cfg_hit       = st_r.hit;
  assign pll_n_ratio   = st_r.pllcfg[SSA_N_LSB +: SSA_N_W];
  assign pll_m_ratio   = st_r.pllcfg[SSA_M_LSB +: SSA_M_W];
  assign pll_test_mode = st_r.pllcfg[SSA_TEST_BIT];

  // Divide PLL output by 2 and 4 for the media cores
  always_ff @(posedge pll_clk)
  begin
    if (!global_reset_pin_n)
    begin
      div_r <= 2'b00;
    end
    else
    begin
      div_r <= div_r + 2'b01;
    end
  end

  assign core_fast_tick = div_r[0];
  assign core_slow_tick = div_r[1];

  a_pll_reset_val: assert property (@(posedge ref_clk)
    !global_reset_pin_n |=> st_r.pllcfg == SSA_PLLCFG_RST)
    else $error("pll register not at default after global reset");
  a_pll_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!global_reset_pin_n)
    (st_r.pllcfg & ~SSA_PLLCFG_WMASK) == 32'h0000_0000)
    else $error("reserved pll bits nonzero");
  a_pll_bus_rst: assert property (@(posedge ref_clk)
    global_reset_pin_n && !rstn |=> st_r.pllcfg == $past(st_nxt.pllcfg))
    else $error("bus reset disturbed pll register");
  a_alias_rst: assert property (@(posedge ref_clk)
    !rstn |=> st_r.alias_w == SSA_ALIAS_RST)
    else $error("alias not zero after reset");
  a_alias_be_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_ALIAS[7:2] && !cfg_be[3]
    |=> st_r.alias_w[31:24] == $past(st_r.alias_w[31:24]))
    else $error("alias byte changed without enable");
  a_alias_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_ALIAS[7:2] && cfg_be == 4'hF
    |=> st_r.alias_w == $past(cfg_wdata))
    else $error("alias write lost");
  a_vend_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg_rd && !cfg_wr && cfg_addr[7:2] == SSA_OFS_SUBSYS_VEND[7:2]
    |=> cfg_rdata[15:0] == $past(st_r.alias_w[15:0]) && cfg_hit)
    else $error("vendor id read not aliased");
  a_pll_n_out: assert property (@(posedge ref_clk) disable iff (!global_reset_pin_n)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2] && cfg_be[1]
    |=> pll_n_ratio == $past(cfg_wdata[10:8]))
    else $error("n ratio not updated");
  a_pll_m_out: assert property (@(posedge ref_clk) disable iff (!global_reset_pin_n)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2] && cfg_be[0]
    |=> pll_m_ratio == $past(cfg_wdata[4:0]))
    else $error("m ratio not updated");
  a_test_bit: assert property (@(posedge ref_clk) disable iff (!global_reset_pin_n)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2] && cfg_be[2]
    |=> pll_test_mode == $past(cfg_wdata[16]))
    else $error("test bit not updated");
  a_rsvd_hi_read: assert property (@(posedge ref_clk)
    disable iff (!rstn || !global_reset_pin_n)
    cfg_rd && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2] |=> cfg_rdata[15:11] == 5'h00)
    else $error("pll bits 15 to 11 read nonzero");
  a_rsvd_mid_read: assert property (@(posedge ref_clk)
    disable iff (!rstn || !global_reset_pin_n)
    cfg_rd && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2] |=> cfg_rdata[7:5] == 3'h0)
    else $error("pll bits 7 to 5 read nonzero");
  a_rsvd_top_read: assert property (@(posedge ref_clk)
    disable iff (!rstn || !global_reset_pin_n)
    cfg_rd && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2] |=> cfg_rdata[31:17] == 15'h0000)
    else $error("pll bits 31 to 17 read nonzero");
  a_dev_half_read: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    cfg_rd && !cfg_wr && cfg_addr[7:2] == SSA_OFS_SUBSYS_VEND[7:2]
    |=> cfg_rdata[SSA_DEV_LSB +: 16] == $past(st_r.alias_w[31:16]) && cfg_hit)
    else $error("device id read not aliased");
  a_alias_ro_view: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_SUBSYS_VEND[7:2] |=> $stable(st_r.alias_w))
    else $error("write to id view changed alias");
  a_alias_keep_b0: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_ALIAS[7:2] && !cfg_be[0]
    |=> st_r.alias_w[7:0] == $past(st_r.alias_w[7:0]))
    else $error("alias byte 0 changed without enable");
  a_alias_keep_b1: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_ALIAS[7:2] && !cfg_be[1]
    |=> st_r.alias_w[15:8] == $past(st_r.alias_w[15:8]))
    else $error("alias byte 1 changed without enable");
  a_alias_keep_b2: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_ALIAS[7:2] && !cfg_be[2]
    |=> st_r.alias_w[23:16] == $past(st_r.alias_w[23:16]))
    else $error("alias byte 2 changed without enable");
  a_pll_be_keep: assert property (@(posedge ref_clk)
    disable iff (!global_reset_pin_n)
    cfg_wr && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2] && !cfg_be[0] |=> $stable(pll_m_ratio))
    else $error("m ratio changed without enable");
  a_fast_toggle: assert property (@(posedge pll_clk)
    disable iff (!global_reset_pin_n)
    $past(global_reset_pin_n) |-> core_fast_tick != $past(core_fast_tick))
    else $error("fast core tick not half of pll clock");
  a_slow_toggle: assert property (@(posedge pll_clk)
    disable iff (!global_reset_pin_n)
    $past(global_reset_pin_n) && $past(core_fast_tick) |-> core_slow_tick != $past(core_slow_tick))
    else $error("slow core tick not quarter of pll clock");

  c_alias_wr: cover property (@(posedge ref_clk) cfg_wr && cfg_addr[7:2] == SSA_OFS_ALIAS[7:2]);
  c_pll_wr: cover property (@(posedge ref_clk) cfg_wr && cfg_addr[7:2] == SSA_OFS_PLLCFG[7:2]);
  c_vend_rd: cover property (@(posedge ref_clk) cfg_rd && cfg_addr[7:2] == SSA_OFS_SUBSYS_VEND[7:2]);
  c_test_on: cover property (@(posedge ref_clk) pll_test_mode);
endmodule

// File: ssa_host.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
module ssa_host (
  // Clock
  input  wire logic        ref_clk,
  // Configuration access
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic      [7:0]  cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_hit
);
  initial
  begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic h);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    // Answer stands for the cycle after the request edge
    @(posedge ref_clk);
    d = cfg_rdata;
    h = cfg_hit;
  endtask
endmodule

// File: subsystem_alias_and_pll_config_regs_test.sv
// Testbench for the subsystem alias and PLL configuration registers
`timescale 1ns/1ps
module subsystem_alias_and_pll_config_regs_test;
  import ssa_pkg::*;
  logic ref_clk = 0, pll_clk = 0, rstn = 0, global_reset_pin_n = 0, rd, wr, hit, ft, st, tm, h;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdat, d;
  logic [2:0] nr;
  logic [4:0] mr;
  int n_errors = 0, num_checks = 0, nf = 0, ns = 0, f0, s0;
  initial forever #4 ref_clk = ~ref_clk;
  initial forever #6.25 pll_clk = ~pll_clk;
  always @(posedge ft) nf++;
  always @(posedge st) ns++;
  ssa_host host_u (.ref_clk(ref_clk), .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(addr), .cfg_be(be),
    .cfg_wdata(wd), .cfg_rdata(rdat), .cfg_hit(hit));
  ssa_cfg_regs dut_u (.ref_clk(ref_clk), .rstn(rstn), .global_reset_pin_n(global_reset_pin_n),
    .cfg_rd(rd),
    .cfg_wr(wr), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rdat), .cfg_hit(hit),
    .pll_n_ratio(nr), .pll_m_ratio(mr), .pll_test_mode(tm), .pll_clk(pll_clk),
    .core_fast_tick(ft), .core_slow_tick(st));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic eh);
    host_u.rd(a, d, h);
    chk("cfg_rdata", e, d);
    chk("cfg_hit", {31'h0, eh}, {31'h0, h});
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_errors++;
    final_report();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    global_reset_pin_n <= 1'b1;
    rchk(SSA_OFS_ALIAS, 32'h0000_0000, 1'b1);
    rchk(SSA_OFS_PLLCFG, 32'h0000_0305, 1'b1);
    chk("pll_ratio", 32'h0000_0305, {20'h0, tm, nr, 3'h0, mr});
    $display("Test reset values done");
    host_u.wr(SSA_OFS_ALIAS, 4'hF, 32'h1234_5678);
    rchk(SSA_OFS_ALIAS, 32'h1234_5678, 1'b1);
    host_u.wr(SSA_OFS_ALIAS, 4'b0101, 32'hAAAA_AAAA);
    rchk(SSA_OFS_ALIAS, 32'h12AA_56AA, 1'b1);
    rchk(SSA_OFS_SUBSYS_VEND, 32'h12AA_56AA, 1'b1);
    host_u.wr(SSA_OFS_SUBSYS_VEND, 4'hF, 32'h0000_0000);
    rchk(SSA_OFS_SUBSYS_VEND, 32'h12AA_56AA, 1'b1);
    host_u.wr(SSA_OFS_ALIAS, 4'b1010, 32'h5555_5555);
    rchk(SSA_OFS_SUBSYS_VEND, 32'h55AA_55AA, 1'b1);
    rchk(8'h58, 32'h0000_0000, 1'b0);
    $display("Test alias done");
    host_u.wr(SSA_OFS_PLLCFG, 4'hF, 32'hFFFF_FFFF);
    rchk(SSA_OFS_PLLCFG, 32'h0001_071F, 1'b1);
    chk("pll_out", 32'h0000_0F1F, {20'h0, tm, nr, 3'h0, mr});
    host_u.wr(SSA_OFS_PLLCFG, 4'b0010, 32'h0000_0000);
    rchk(SSA_OFS_PLLCFG, 32'h0001_001F, 1'b1);
    $display("Test PLL register done");
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk(SSA_OFS_PLLCFG, 32'h0001_001F, 1'b1);
    rchk(SSA_OFS_ALIAS, 32'h0000_0000, 1'b1);
    global_reset_pin_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    global_reset_pin_n <= 1'b1;
    rchk(SSA_OFS_PLLCFG, 32'h0000_0305, 1'b1);
    chk("pll_pins", 32'h0000_0305, {20'h0, tm, nr, 3'h0, mr});
    $display("Test resets done");
    repeat (4) @(posedge pll_clk);
    f0 = nf;
    s0 = ns;
    repeat (16) @(posedge pll_clk);
    chk("fast_rises", 16 / SSA_DIV_FAST, nf - f0);
    chk("slow_rises", 16 / SSA_DIV_SLOW, ns - s0);
    $display("Test dividers done");
    final_report();
  end
endmodule
